//--- core/cell_defines.svh
// register offsets, field positions, reset values and bus answers of the storage pair
`ifndef CELL_DEFINES_SVH
`define CELL_DEFINES_SVH
`define CELL_ADDR_W 4
`define CELL_CFG_OFFSET 4'h0
`define CELL_STATUS_OFFSET 4'h4
`define CELL_ELEM_CFG_W 4
`define CELL_LATCH_BIT 8
`define CELL_CFG_W 9
`define CELL_CFG_RESET 9'h000
`define CELL_STATUS_Q_LSB 0
`define CELL_STATUS_GLOBAL_BIT 2
`define CELL_RESP_OKAY 2'h0
`define CELL_RESP_SLVERR 2'h2
`endif

//--- core/cell_pkg.sv
// types shared by the storage pair and its storage elements
package cell_pkg;
  typedef struct packed {
    logic sr_value;
    logic sr_enable;
    logic enable_tied;
    logic clk_invert;
  } elem_cfg_t;
  typedef struct packed {
    logic cell_clock;
    logic enable;
    logic local_clear;
    logic global_clear;
    logic data;
  } elem_in_t;
  typedef enum logic [2:0] {
    SEL_CFG = 3'b001,
    SEL_STATUS = 3'b010,
    SEL_NONE = 3'b100
  } reg_sel_t;
endpackage

//--- core/storage_element.sv
// one storage element: flip-flop or latch with clock inversion, enable and preset/clear
`timescale 1ns/1ps
module storage_element (
  input wire logic clk,
  input wire logic rst_n,
  input cell_pkg::elem_cfg_t cfg,
  input wire logic latch_mode,
  input wire logic reload,
  input cell_pkg::elem_in_t pins,
  output logic q
);
  import cell_pkg::*;
  logic q_r, q_nxt, act_prev_r, act_prev_nxt;
  logic active, rise, en_eff, force_v;

  always_comb begin
    active = pins.cell_clock ^ cfg.clk_invert;
    rise = active & ~act_prev_r;
    en_eff = cfg.enable_tied | pins.enable;
    force_v = pins.global_clear | reload | (pins.local_clear & cfg.sr_enable);
    act_prev_nxt = active;
    q_nxt = q_r;
    if (force_v) begin
      q_nxt = cfg.sr_value;
    end else if (!en_eff) begin
      q_nxt = q_r;
    end else if (latch_mode) begin
      // latch is transparent while the active clock level is low
      if (!active) begin
        q_nxt = pins.data;
      end
    end else if (rise) begin
      q_nxt = pins.data;
    end
  end

  // previous level resets high so release never looks like a clock edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= 1'b0;
      act_prev_r <= 1'b1;
    end else begin
      q_r <= q_nxt;
      act_prev_r <= act_prev_nxt;
    end
  end

  assign q = q_r;
endmodule

//--- core/logic_cell.sv
// logic cell storage pair with its configuration registers on an AXI4-Lite slave
//
// Behaviour
// - two D flip-flops, one shared clock, enable
// - either element may ignore the shared enable
// - option: both elements act as latches
// - per-element clock inversion selects active edge
// - enable active high; low holds both outputs
// - unconnected enable counts as always asserted
// - power-up, global or local clear force value
// - flip-flop loads data on active edge only
// - latch follows data while clock low
// - local clear active high, per-element polarity, disable
// - global clear forces same value; clear default
// - per-element value also sets post-configuration state
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "cell_defines.svh"
module logic_cell #(
  parameter int ADDR_W = `CELL_ADDR_W,
  parameter int NUM_ELEM = 2
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic CELL_CLOCK,
  input wire logic SHARED_ENABLE_INPUT,
  input wire logic LOCAL_PRESET_CLEAR,
  input wire logic GLOBAL_PRESET_CLEAR,
  input wire logic [1:0] DATA_IN,
  output logic [1:0] CELL_Q
);
  import cell_pkg::*;

  // the register map and the status layout only fit these values
  if (ADDR_W < `CELL_ADDR_W || NUM_ELEM != 2) begin : g_bad_param
    $error("logic_cell: address width below 4 or element count other than 2");
  end

  // decoding shared by the read and the write path
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    reg_sel_t s;
    s = SEL_NONE;
    if (addr == ADDR_W'(`CELL_CFG_OFFSET)) begin
      s = SEL_CFG;
    end else if (addr == ADDR_W'(`CELL_STATUS_OFFSET)) begin
      s = SEL_STATUS;
    end
    return s;
  endfunction

  // write channel state
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  // read channel state
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  // configuration state
  logic [`CELL_CFG_W-1:0] cfg_r, cfg_nxt;
  logic reload_r, reload_nxt;

  logic [1:0] q_w;
  logic commit;
  reg_sel_t wsel, rsel;

  assign S_AXI_AWREADY = ~aw_got_r & ~bvalid_r;
  assign S_AXI_WREADY = ~w_got_r & ~bvalid_r;
  assign S_AXI_ARREADY = ~rvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  // address and data are held until both are present, so they may come in either order
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    commit = aw_got_r & w_got_r;
    wsel = decode(awaddr_r);
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_nxt = 1'b1;
      wdata_nxt = S_AXI_WDATA;
      wstrb_nxt = S_AXI_WSTRB;
    end
    if (commit) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (wsel == SEL_NONE) ? `CELL_RESP_SLVERR : `CELL_RESP_OKAY;
    end else if (bvalid_r && S_AXI_BREADY) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `CELL_RESP_OKAY;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // a configuration write with byte lane 0 or 1 strobed reloads both elements with their preset/clear value
  always_comb begin
    cfg_nxt = cfg_r;
    reload_nxt = 1'b0;
    if (commit && wsel == SEL_CFG) begin
      if (wstrb_r[0]) begin
        cfg_nxt[7:0] = wdata_r[7:0];
      end
      if (wstrb_r[1]) begin
        cfg_nxt[`CELL_LATCH_BIT] = wdata_r[`CELL_LATCH_BIT];
      end
      reload_nxt = wstrb_r[0] | wstrb_r[1];
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_r <= `CELL_CFG_RESET;
      reload_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      reload_r <= reload_nxt;
    end
  end

  // read answer is registered one cycle after the address is taken
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    rsel = decode(S_AXI_ARADDR);
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = 32'h00000000;
      rresp_nxt = `CELL_RESP_OKAY;
      case (rsel)
        SEL_CFG: begin
          rdata_nxt[`CELL_CFG_W-1:0] = cfg_r;
        end
        SEL_STATUS: begin
          rdata_nxt[`CELL_STATUS_Q_LSB+1:`CELL_STATUS_Q_LSB] = q_w;
          rdata_nxt[`CELL_STATUS_GLOBAL_BIT] = GLOBAL_PRESET_CLEAR;
        end
        default: begin
          rresp_nxt = `CELL_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `CELL_RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // both elements see the same clock, enable and clear pins; only configuration and data differ
  generate
    for (genvar e = 0; e < NUM_ELEM; e++) begin : g_elem
      elem_cfg_t ecfg;
      elem_in_t epins;
      assign ecfg = elem_cfg_t'(cfg_r[e*`CELL_ELEM_CFG_W +: `CELL_ELEM_CFG_W]);
      assign epins.cell_clock = CELL_CLOCK;
      assign epins.enable = SHARED_ENABLE_INPUT;
      assign epins.local_clear = LOCAL_PRESET_CLEAR;
      assign epins.global_clear = GLOBAL_PRESET_CLEAR;
      assign epins.data = DATA_IN[e];
      storage_element u_elem (
        .clk(MCLK),
        .rst_n(ARST_N),
        .cfg(ecfg),
        .latch_mode(cfg_r[`CELL_LATCH_BIT]),
        .reload(reload_r),
        .pins(epins),
        .q(q_w[e])
      );
    end
  endgenerate

  assign CELL_Q = q_w;

  // protection bits carry no meaning for this slave
  logic unused_prot;
  assign unused_prot = ^{S_AXI_AWPROT, S_AXI_ARPROT, wdata_r[31:9], wstrb_r[3:2]};
endmodule

//--- test/logic_cell_monitor.sv
// checker on the storage pair's top-level ports
`timescale 1ns/1ps
module logic_cell_monitor #(
  parameter int ADDR_W = 4
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic GLOBAL_PRESET_CLEAR,
  input wire logic [1:0] CELL_Q
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  chk_w_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while response pending");
  chk_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while data pending");
  chk_r_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  chk_b_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write answer late");
  chk_status_q: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 4'h4 |=>
    S_AXI_RDATA[2:0] == {$past(GLOBAL_PRESET_CLEAR), $past(CELL_Q)}) else $error("status mismatch");
  // a held global clear pins the outputs at their configured value
  chk_global_hold: assert property (GLOBAL_PRESET_CLEAR && $past(GLOBAL_PRESET_CLEAR) |=> $stable(CELL_Q))
    else $error("output moved under global clear");
endmodule
bind logic_cell logic_cell_monitor #(.ADDR_W(ADDR_W)) mon (.*);

//--- test/user_side.sv
// model of the user logic driving the cell pins
`timescale 1ns/1ps
module user_side (
  input wire logic clk,
  output logic k,
  output logic en,
  output logic lc,
  output logic gc,
  output logic [1:0] d
);
  // pins stand still between calls, as routed logic holds them
  initial {k, en, lc, gc, d} = 6'h00;
  task set(input logic k_v, en_v, lc_v, gc_v, input logic [1:0] d_v);
    @(posedge clk);
    {k, en, lc, gc, d} <= {k_v, en_v, lc_v, gc_v, d_v};
  endtask
endmodule

//--- test/logic_cell_tb.sv
// self-checking bench of the storage pair
`timescale 1ns/1ps
module logic_cell_tb;
  logic MCLK = 0, ARST_N = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID;
  logic [3:0] S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'hF;
  logic [2:0] S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd_v;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, CELL_Q, rs;
  wire CELL_CLOCK, SHARED_ENABLE_INPUT, LOCAL_PRESET_CLEAR, GLOBAL_PRESET_CLEAR;
  wire [1:0] DATA_IN;
  int mismatches = 0, n_tests = 0, cyc = 0;
  logic_cell dut (.*);
  user_side p (.clk(MCLK), .k(CELL_CLOCK), .en(SHARED_ENABLE_INPUT), .lc(LOCAL_PRESET_CLEAR),
    .gc(GLOBAL_PRESET_CLEAR), .d(DATA_IN));
  always #5 MCLK = ~MCLK;
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_of_test;
    end
  end
  task chs(input logic [1:0] g, e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge MCLK);
    {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_AWVALID, S_AXI_WVALID} <= {a, d, 2'h3};
    // address and data may be taken at different edges
    do begin
      @(posedge MCLK);
      if (!aw && S_AXI_AWREADY) begin aw = 1; S_AXI_AWVALID <= 0; end
      if (!w && S_AXI_WREADY) begin w = 1; S_AXI_WVALID <= 0; end
    end while (!(aw && w));
    do @(posedge MCLK); while (!S_AXI_BVALID);
    S_AXI_BREADY <= 1;
    @(posedge MCLK);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge MCLK);
    {S_AXI_ARADDR, S_AXI_ARVALID} <= {a, 1'b1};
    do @(posedge MCLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 0;
    do @(posedge MCLK); while (!S_AXI_RVALID);
    S_AXI_RREADY <= 1;
    @(posedge MCLK);
    {d, r} = {S_AXI_RDATA, S_AXI_RRESP};
    S_AXI_RREADY <= 0;
  endtask
  // change pins, then let the sampling edge and the output edge pass
  task pin(input logic k, en, lc, gc, input logic [1:0] d);
    p.set(k, en, lc, gc, d);
    repeat (2) @(posedge MCLK);
    #1;
  endtask
  task t_reset_and_bus;
    chs(CELL_Q, 2'h0);
    rd(4'h0, rd_v, rs);
    chk(rd_v, 32'h00000000);
    chs(rs, 2'h0);
    wr(4'h8, 32'h000001FF, rs);
    chs(rs, 2'h2);
    rd(4'h8, rd_v, rs);
    chk(rd_v, 32'h00000000);
    chs(rs, 2'h2);
    // status is read-only: the write is answered but changes nothing
    wr(4'h4, 32'h000001FF, rs);
    chs(rs, 2'h0);
    rd(4'h0, rd_v, rs);
    chk(rd_v, 32'h00000000);
    chs(rs, 2'h0);
  endtask
  task t_flop;
    pin(1'h0, 1'h1, 1'h0, 1'h0, 2'h3);
    pin(1'h1, 1'h1, 1'h0, 1'h0, 2'h3);
    chs(CELL_Q, 2'h3);
    pin(1'h0, 1'h1, 1'h0, 1'h0, 2'h0);
    chs(CELL_Q, 2'h3);
    pin(1'h1, 1'h0, 1'h0, 1'h0, 2'h0);
    chs(CELL_Q, 2'h3);
  endtask
  task t_tie_invert;
    wr(4'h0, 32'h00000012, rs);
    chs(rs, 2'h0);
    pin(1'h0, 1'h0, 1'h0, 1'h0, 2'h3);
    chs(CELL_Q, 2'h0);
    pin(1'h1, 1'h0, 1'h0, 1'h0, 2'h3);
    chs(CELL_Q, 2'h1);
    pin(1'h0, 1'h1, 1'h0, 1'h0, 2'h3);
    chs(CELL_Q, 2'h3);
    pin(1'h1, 1'h1, 1'h0, 1'h0, 2'h0);
    chs(CELL_Q, 2'h2);
  endtask
  task t_clears;
    wr(4'h0, 32'h0000004C, rs);
    chs(rs, 2'h0);
    pin(1'h0, 1'h1, 1'h0, 1'h0, 2'h2);
    chs(CELL_Q, 2'h1);
    pin(1'h1, 1'h1, 1'h0, 1'h0, 2'h2);
    chs(CELL_Q, 2'h2);
    pin(1'h1, 1'h1, 1'h1, 1'h0, 2'h2);
    chs(CELL_Q, 2'h1);
    wr(4'h0, 32'h00000008, rs);
    chs(rs, 2'h0);
    pin(1'h0, 1'h1, 1'h0, 1'h0, 2'h2);
    pin(1'h1, 1'h1, 1'h0, 1'h0, 2'h2);
    pin(1'h1, 1'h1, 1'h1, 1'h0, 2'h2);
    chs(CELL_Q, 2'h2);
    pin(1'h1, 1'h1, 1'h1, 1'h1, 2'h2);
    chs(CELL_Q, 2'h1);
    rd(4'h4, rd_v, rs);
    chk(rd_v, 32'h00000005);
    chs(rs, 2'h0);
    pin(1'h1, 1'h1, 1'h0, 1'h0, 2'h2);
  endtask
  task t_latch;
    wr(4'h0, 32'h00000100, rs);
    chs(rs, 2'h0);
    pin(1'h0, 1'h1, 1'h0, 1'h0, 2'h3);
    chs(CELL_Q, 2'h3);
    pin(1'h1, 1'h1, 1'h0, 1'h0, 2'h0);
    chs(CELL_Q, 2'h3);
    pin(1'h0, 1'h1, 1'h0, 1'h0, 2'h0);
    chs(CELL_Q, 2'h0);
    pin(1'h0, 1'h0, 1'h0, 1'h0, 2'h3);
    chs(CELL_Q, 2'h0);
  endtask
  // a reset in mid-run must clear a loaded output and the configuration
  task t_reset_mid;
    pin(1'h0, 1'h1, 1'h0, 1'h0, 2'h3);
    chs(CELL_Q, 2'h3);
    @(posedge MCLK);
    ARST_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    #1;
    chs(CELL_Q, 2'h0);
    @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    #1;
    chs(CELL_Q, 2'h0);
    rd(4'h0, rd_v, rs);
    chk(rd_v, 32'h00000000);
    chs(rs, 2'h0);
  endtask
  initial begin
    repeat (5) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    #1;
    t_reset_and_bus;
    t_flop;
    t_tie_invert;
    t_clears;
    t_latch;
    t_reset_mid;
    end_of_test;
  end
endmodule
